// file: dcfgp_consts.vh
// Shared constants for the dual-clock Gray-pointer buffer with word protection.
`ifndef DCFGP_CONSTS_VH
`define DCFGP_CONSTS_VH

// Error correction status codes.
`define DCFGP_ECC_NONE      2'b00
`define DCFGP_ECC_ILLEGAL   2'b01
`define DCFGP_ECC_CORR      2'b10
`define DCFGP_ECC_UNCORR    2'b11

// Physical storage organisation when protection is on.
`define DCFGP_WORD_W        32
`define DCFGP_ADDR_W        9
`define DCFGP_HALF_D        16
`define DCFGP_HALF_C        22
`define DCFGP_HAM_CHK       5
`define DCFGP_CODE_W        44

// Number of flops a pointer passes in the far domain.
`define DCFGP_SYNC_STAGES   3

`endif

// file: dcfgp_ecc.v
// Interleaved two-way SEC-DED encoder and decoder for one 32-bit storage word.
`timescale 1ns/1ps
`default_nettype none

module dcfgp_ecc (
    input  wire [31:0] encIn,     // Padded data word to protect.
    output wire [43:0] encOut,    // Interleaved code word to store.
    input  wire [43:0] decIn,     // Code word read from storage.
    output wire [31:0] decOut,    // Corrected data word.
    output wire [1:0]  decStatus  // Integrity of the word read.
);
`include "dcfgp_consts.vh"

    // Hamming encode: positions 1..21, check bits at powers of two, overall parity at 0.
    function [21:0] hamEnc;
        input [15:0] d;
        integer p;
        integer k;
        integer c;
        reg [21:0] w;
        begin
            w = 22'h0;
            k = 0;
            for (p = 1; p < 22; p = p + 1) begin
                if ((p & (p - 1)) != 0) begin
                    w[p] = d[k];
                    k = k + 1;
                end
            end
            for (c = 0; c < `DCFGP_HAM_CHK; c = c + 1) begin
                for (p = 1; p < 22; p = p + 1) begin
                    if ((((p >> c) & 1) == 1) && (p != (1 << c)))
                        w[1 << c] = w[1 << c] ^ w[p];
                end
            end
            w[0] = ^w[21:1];
            hamEnc = w;
        end
    endfunction

    // Hamming decode: returns {status, data}; a double error in one half is flagged only.
    function [17:0] hamDec;
        input [21:0] cw;
        integer p;
        integer k;
        reg [21:0] w;
        reg [4:0]  syn;
        reg        par;
        reg [15:0] d;
        reg [1:0]  st;
        begin
            w = cw;
            syn = 5'h0;
            d = 16'h0;
            for (p = 1; p < 22; p = p + 1) begin
                if (w[p])
                    syn = syn ^ p[4:0];
            end
            par = ^w;
            st = `DCFGP_ECC_NONE;
            if (par && (syn < 5'h16)) begin
                w[syn] = ~w[syn];
                st = `DCFGP_ECC_CORR;
            end else if (par || (syn != 5'h0)) begin
                st = `DCFGP_ECC_UNCORR;
            end
            k = 0;
            for (p = 1; p < 22; p = p + 1) begin
                if ((p & (p - 1)) != 0) begin
                    d[k] = w[p];
                    k = k + 1;
                end
            end
            hamDec = {st, d};
        end
    endfunction

    // interleave halves.
    // Even data bits feed half 0, odd bits half 1, and stored bits alternate halves, so a run of
    // two adjacent flips hits each half once and is corrected, while three adjacent flips leave a
    // double error in one half, which is detected but cannot be repaired.
    genvar g;
    genvar j;
    generate
        for (g = 0; g < 2; g = g + 1) begin : hb
            wire [15:0] hd;
            wire [21:0] hc;
            wire [21:0] rc;
            wire [17:0] res;
            for (j = 0; j < `DCFGP_HALF_D; j = j + 1) begin : db
                assign hd[j]         = encIn[2 * j + g];
                assign decOut[2*j+g] = res[j];
            end
            for (j = 0; j < `DCFGP_HALF_C; j = j + 1) begin : cb
                assign encOut[2 * j + g] = hc[j];
                assign rc[j]             = decIn[2 * j + g];
            end
            assign hc  = hamEnc(hd);
            assign res = hamDec(rc);
        end
    endgenerate

    // merge halves.
    // The worse half wins; the illegal code is never produced.
    assign decStatus = (hb[0].res[17:16] == `DCFGP_ECC_UNCORR || hb[1].res[17:16] == `DCFGP_ECC_UNCORR) ?
                       `DCFGP_ECC_UNCORR :
                       ((hb[0].res[17:16] == `DCFGP_ECC_CORR || hb[1].res[17:16] == `DCFGP_ECC_CORR) ?
                       `DCFGP_ECC_CORR : `DCFGP_ECC_NONE);

endmodule

`default_nettype wire

// file: dcfgp_fifo.v
// Dual-clock buffer with Gray pointers, optional word protection and a two-entry output stage.
//
// Notes on behaviour
// - Pointers cross between clock domains only as Gray code, one bit per step.
// - Gray pointer follows reflected order 000, 001, 011, 010, 110 and onward.
// - A metastable capture resolves only to the old or the new pointer.
// - Pointer bit skew is bounded; captured pointers are accepted only when stable.
// - Protection corrects single and double-adjacent errors, detects triple-adjacent errors.
// - Protection adds a two-bit status reporting each word read.
// - Status 00 clean, 01 illegal, 10 corrected, 11 uncorrectable data shown.
// - Protected storage uses 32-bit by 512-word blocks, unused bits tied high.
// - Protection only applies with equal write and read widths.
// - Overflow guard is optional; without it the writer must not write when full.
// - Underflow guard is optional; without it the reader must not read when empty.
`timescale 1ns/1ps
`default_nettype none

module dcfgp_fifo #(
    parameter DATA_W         = 32,  // Data width, both ports, at most 32.
    parameter ADDR_W         = 9,   // Log2 of depth.
    parameter ECC_EN         = 1,   // 1 adds word protection and status.
    parameter OVERFLOW_CHECK = 1,   // 1 ignores writes while full.
    parameter UNDERFLOW_CHECK = 1   // 1 ignores reads while empty.
) (
    input  wire              mclk,        // Write-side clock.
    input  wire              reset_n,     // Asynchronous reset, active low.
    input  wire              rdClk,       // Read-side clock.
    input  wire              wrReq,       // Write request, one word per cycle.
    input  wire [DATA_W-1:0] wrData,      // Write data.
    input  wire [43:0]       wrFlip,      // Stored-bit flip mask for error injection.
    output reg               wrFull,      // Buffer full, write domain.
    input  wire              rdReq,       // Read request, rdClk domain.
    output reg               rdEmpty,     // Buffer empty, read domain.
    output reg               rdAck,       // A read was taken one cycle earlier.
    output reg               outValid,    // Output word valid.
    input  wire              outReady,    // Receiver takes the output word.
    output reg  [DATA_W-1:0] outData,     // Output word.
    output reg  [1:0]        outEccStatus // Integrity of the output word.
);
`include "dcfgp_consts.vh"

    // one shared width.
    // Both ports use DATA_W, so protection never meets a mixed-width pair.
    localparam PW    = ADDR_W + 1;
    localparam DEPTH = 1 << ADDR_W;
    localparam OW    = DATA_W + 2;

    // Reset release, one synchroniser per clock.
    reg [1:0] wRst;
    reg [1:0] rRst;
    wire      wRstN = wRst[1];
    wire      rRstN = rRst[1];

    always @(posedge mclk or negedge reset_n) begin
        if (!reset_n)
            wRst <= 2'b00;
        else
            wRst <= {wRst[0], 1'b1};
    end

    always @(posedge rdClk or negedge reset_n) begin
        if (!reset_n)
            rRst <= 2'b00;
        else
            rRst <= {rRst[0], 1'b1};
    end

    // Storage, one array written on mclk and read on rdClk.
    reg [43:0]  mem [0:DEPTH-1];
    wire [31:0] padded;
    wire [43:0] encWord;
    wire [43:0] storeWord;
    reg  [43:0] memQ;
    wire [31:0] decWord;
    wire [1:0]  decStatus;

    generate
        if (DATA_W < `DCFGP_WORD_W) begin : padg
            assign padded = {{(`DCFGP_WORD_W - DATA_W){1'b1}}, wrData};
        end else begin : fullg
            assign padded = wrData[31:0];
        end
    endgenerate

    dcfgp_ecc ecc (
        .encIn     (padded),
        .encOut    (encWord),
        .decIn     (memQ),
        .decOut    (decWord),
        .decStatus (decStatus)
    );

    assign storeWord = ((ECC_EN != 0) ? encWord : {{(`DCFGP_CODE_W - `DCFGP_WORD_W){1'b1}}, padded}) ^ wrFlip;
    wire [DATA_W-1:0] rdWord   = (ECC_EN != 0) ? decWord[DATA_W-1:0] : memQ[DATA_W-1:0];
    wire [1:0]        rdStatus = (ECC_EN != 0) ? decStatus : `DCFGP_ECC_NONE;

    // Write domain pointers and the captured read pointer.
    reg  [PW-1:0] wrBin;
    reg  [PW-1:0] wrGray;
    reg  [PW-1:0] rpS1;
    reg  [PW-1:0] rpS2;
    reg  [PW-1:0] rpS3;
    reg  [PW-1:0] rpSync;
    reg  [PW-1:0] rdGray;

    wire          wrDo       = wrReq && (!wrFull || (OVERFLOW_CHECK == 0));
    wire [PW-1:0] next_wrBin = wrDo ? wrBin + {{(PW-1){1'b0}}, 1'b1} : wrBin;
    wire [PW-1:0] next_wrGray = next_wrBin ^ (next_wrBin >> 1);
    wire [PW-1:0] next_rpSync = (rpS2 == rpS3) ? rpS3 : rpSync;
    wire [PW-1:0] fullMatch   = {~next_rpSync[PW-1:PW-2], next_rpSync[PW-3:0]};

    always @(posedge mclk) begin
        if (wrDo)
            mem[wrBin[ADDR_W-1:0]] <= storeWord;
    end

    // source register plus three far stages.
    // The first stage may go metastable; because one bit moves per step it can only settle on
    // the old or new count, and the agreement filter rejects any half-settled mixture.
    // old or new count only.
    always @(posedge mclk or negedge wRstN) begin
        if (!wRstN) begin
            wrBin  <= {PW{1'b0}};
            wrGray <= {PW{1'b0}};
            rpS1   <= {PW{1'b0}};
            rpS2   <= {PW{1'b0}};
            rpS3   <= {PW{1'b0}};
            rpSync <= {PW{1'b0}};
            wrFull <= 1'b0;
        end else begin
            wrBin  <= next_wrBin;
            wrGray <= next_wrGray;
            rpS1   <= rdGray;
            rpS2   <= rpS1;
            rpS3   <= rpS2;
            rpSync <= next_rpSync;
            wrFull <= (next_wrGray == fullMatch);
        end
    end

    // Read domain pointers and the captured write pointer.
    reg  [PW-1:0] rdBin;
    reg  [PW-1:0] wpS1;
    reg  [PW-1:0] wpS2;
    reg  [PW-1:0] wpS3;
    reg  [PW-1:0] wpSync;
    reg           inflight;
    reg  [OW-1:0] skid;
    reg           skidValid;

    // Room counts the word already in flight from storage, so a stalled receiver never drops one.
    wire       outFire = outValid && outReady;
    wire [1:0] held    = {1'b0, outValid} + {1'b0, skidValid} + {1'b0, inflight};
    wire       room    = (held - {1'b0, outFire}) < 2'd2;

    wire          rdDo        = rdReq && room && (!rdEmpty || (UNDERFLOW_CHECK == 0));
    wire [PW-1:0] next_rdBin  = rdDo ? rdBin + {{(PW-1){1'b0}}, 1'b1} : rdBin;
    wire [PW-1:0] next_rdGray = next_rdBin ^ (next_rdBin >> 1);
    wire [PW-1:0] next_wpSync = (wpS2 == wpS3) ? wpS3 : wpSync;

    always @(posedge rdClk) begin
        if (rdDo)
            memQ <= mem[rdBin[ADDR_W-1:0]];
    end

    // write pointer crosses by three stages.
    always @(posedge rdClk or negedge rRstN) begin
        if (!rRstN) begin
            rdBin    <= {PW{1'b0}};
            rdGray   <= {PW{1'b0}};
            wpS1     <= {PW{1'b0}};
            wpS2     <= {PW{1'b0}};
            wpS3     <= {PW{1'b0}};
            wpSync   <= {PW{1'b0}};
            rdEmpty  <= 1'b1;
            rdAck    <= 1'b0;
            inflight <= 1'b0;
        end else begin
            rdBin    <= next_rdBin;
            rdGray   <= next_rdGray;
            wpS1     <= wrGray;
            wpS2     <= wpS1;
            wpS3     <= wpS2;
            wpSync   <= next_wpSync;
            rdEmpty  <= (next_rdGray == next_wpSync);
            rdAck    <= rdDo;
            inflight <= rdDo;
        end
    end

    // Two-entry output stage: the output register plus one skid slot behind it.
    always @(posedge rdClk or negedge rRstN) begin
        if (!rRstN) begin
            outValid     <= 1'b0;
            outData      <= {DATA_W{1'b0}};
            outEccStatus <= `DCFGP_ECC_NONE;
            skid         <= {OW{1'b0}};
            skidValid    <= 1'b0;
        end else if (outFire || !outValid) begin
            if (skidValid) begin
                outValid     <= 1'b1;
                outEccStatus <= skid[OW-1:OW-2];
                outData      <= skid[DATA_W-1:0];
                skidValid    <= inflight;
                skid         <= {rdStatus, rdWord};
            end else begin
                outValid     <= inflight;
                outEccStatus <= rdStatus;
                outData      <= rdWord;
            end
        end else if (inflight) begin
            skid      <= {rdStatus, rdWord};
            skidValid <= 1'b1;
        end
    end

endmodule

`default_nettype wire

// file: dcfgp_fifo_assertions.sv
// Port-level checker for the dual-clock buffer.
`timescale 1ns/1ps
`default_nettype none
module dcfgp_fifo_checker #(
    parameter UNDERFLOW_CHECK = 1
) (
    input wire logic       mclk,        // Write clock.
    input wire logic       reset_n,     // Reset, active low.
    input wire logic       rdClk,       // Read clock.
    input wire logic       wrReq,       // Write request.
    input wire logic       wrFull,      // Full flag.
    input wire logic       rdReq,       // Read request.
    input wire logic       rdEmpty,     // Empty flag.
    input wire logic       rdAck,       // Read taken.
    input wire logic       outValid,    // Output valid.
    input wire logic       outReady,    // Output taken.
    input wire logic [1:0] outEccStatus // Output status.
);
    // Checks on output status codes and hold, acknowledge and valid causes, empty behaviour and the full flag.
    ecc_code_legal_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        outValid |-> outEccStatus != 2'b01) else $error("Reserved status code shown.");
    out_hold_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        outValid && !outReady |=> outValid && $stable(outEccStatus)) else $error("Output word dropped.");
    ack_cause_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        rdAck |-> $past(rdReq) && !$past(rdEmpty)) else $error("Acknowledge without a read.");
    empty_ignore_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        UNDERFLOW_CHECK == 1 && rdReq && rdEmpty |=> !rdAck) else $error("Read taken while empty.");
    ack_valid_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        rdAck |=> outValid) else $error("Read gave no word.");
    valid_cause_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        $rose(outValid) |-> $past(rdAck)) else $error("Word appeared without a read.");
    empty_start_a: assert property (@(posedge rdClk) disable iff (!reset_n)
        $rose(reset_n) |-> rdEmpty [*4]) else $error("Empty flag left too early.");
    full_cause_a: assert property (@(posedge mclk) disable iff (!reset_n)
        $rose(wrFull) |-> $past(wrReq)) else $error("Full flag rose without a write.");
endmodule
bind dcfgp_fifo dcfgp_fifo_checker #(.UNDERFLOW_CHECK(UNDERFLOW_CHECK)) u_chk (.mclk(mclk), .reset_n(reset_n),
    .rdClk(rdClk), .wrReq(wrReq), .wrFull(wrFull), .rdReq(rdReq), .rdEmpty(rdEmpty), .rdAck(rdAck),
    .outValid(outValid), .outReady(outReady), .outEccStatus(outEccStatus));
`default_nettype wire

// file: dcfgp_reader.sv
// Reader-side partner: pulls words out of the buffer and records them.
`timescale 1ns/1ps
`default_nettype none
module dcfgp_reader (
    input  wire logic        rdClk,       // Read clock.
    input  wire logic        enable,      // Allows reads.
    input  wire logic        stall,       // Slow receiver mode.
    input  wire logic        rude,        // Requests even when empty.
    input  wire logic        rdEmpty,     // Buffer empty.
    output var  logic        rdReq,       // Read request.
    input  wire logic        outValid,    // Output valid.
    output var  logic        outReady,    // Receiver accepts.
    input  wire logic [31:0] outData,     // Output word.
    input  wire logic [1:0]  outEccStatus // Output status.
);
    logic [31:0] gotD[$];
    logic [1:0]  gotS[$];
    // Idle until the bench enables reads.
    initial begin
        rdReq = 1'b0;
        outReady = 1'b0;
    end
    // no empty reads unless rude is set
    // A slow receiver takes a word only every other cycle, so the skid entry gets used.
    always @(negedge rdClk) begin
        rdReq <= enable && (rude || !rdEmpty);
        outReady <= stall ? !outReady : 1'b1;
    end
    // Each accepted word is kept with its status.
    always @(posedge rdClk) begin
        if (outValid && outReady) begin
            gotD.push_back(outData);
            gotS.push_back(outEccStatus);
        end
    end
endmodule
`default_nettype wire

// file: testbench.sv
// Self-checking bench for the dual-clock buffer.
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam int AW = 4;
    localparam int DEPTH = 1 << AW;
    logic        mclk, rdClk, reset_n, wrReq, rdReq, wrFull, rdEmpty, rdAck, outValid, outReady;
    logic        rdEn, rdStall, rdRude;
    logic [31:0] wrData, outData;
    logic [43:0] wrFlip;
    logic [1:0]  outEccStatus;
    int          fails, num_checks, i;
    int          acks = 0;
    logic [43:0] flips [4] = '{44'h0, 44'h20, 44'h300, 44'h700000};
    logic [1:0]  stats [4] = '{2'h0, 2'h2, 2'h2, 2'h3};

    dcfgp_fifo #(.ADDR_W(AW)) u_dcfgp_fifo (.mclk(mclk), .reset_n(reset_n), .rdClk(rdClk), .wrReq(wrReq),
        .wrData(wrData), .wrFlip(wrFlip), .wrFull(wrFull), .rdReq(rdReq), .rdEmpty(rdEmpty), .rdAck(rdAck),
        .outValid(outValid), .outReady(outReady), .outData(outData), .outEccStatus(outEccStatus));
    dcfgp_reader u_dcfgp_reader (.rdClk(rdClk), .enable(rdEn), .stall(rdStall), .rude(rdRude), .rdEmpty(rdEmpty),
        .rdReq(rdReq), .outValid(outValid), .outReady(outReady), .outData(outData), .outEccStatus(outEccStatus));

    // Each one-cycle acknowledge is counted mid-cycle, away from the edge that launches it.
    always @(negedge rdClk) begin
        if (rdAck === 1'b1)
            acks++;
    end

    // The read clock is offset so its edges never meet those of mclk.
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;
    initial begin
        rdClk = 1'b0;
        #1.1 forever #3.5 rdClk = ~rdClk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            fails++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic give_verdict;
        $display("Checks %0d, mismatches %0d", num_checks, fails);
        if (fails == 0 && num_checks > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    // Writes are held across the edge; the caller drops wrReq with idle.
    task automatic put(input logic [31:0] d, input logic [43:0] f);
        wrReq = 1'b1;
        wrData = d;
        wrFlip = f;
        @(negedge mclk);
    endtask
    task automatic idle(input int n);
        wrReq = 1'b0;
        wrFlip = 44'h0;
        repeat (n) @(negedge mclk);
    endtask
    // Bounded wait for the partner to hold n words.
    task automatic await(input int n);
        for (int k = 0; k < 4000 && u_dcfgp_reader.gotD.size() < n; k++) @(negedge mclk);
        chk(u_dcfgp_reader.gotD.size(), n);
    endtask

    task automatic test_reset;
        chk(rdEmpty, 1'b1);
        chk(wrFull, 1'b0);
        chk(outValid, 1'b0);
        $display("test_reset done");
    endtask
    // Fill until refused, then drain through a stalling receiver.
    task automatic test_fill;
        for (i = 0; i < DEPTH - 1; i++) put(32'ha000 + i, 44'h0);
        idle(1);
        chk(wrFull, 1'b0);
        put(32'ha000 + DEPTH - 1, 44'h0);
        idle(1);
        chk(wrFull, 1'b1);
        put(32'hdead, 44'h0);
        idle(2);
        rdStall = 1'b1;
        rdEn = 1'b1;
        await(DEPTH);
        repeat (60) @(negedge mclk);
        chk(u_dcfgp_reader.gotD.size(), DEPTH);
        for (i = 0; i < DEPTH; i++) chk(u_dcfgp_reader.gotD[i], 32'ha000 + i);
        chk(rdEmpty, 1'b1);
        chk(wrFull, 1'b0);
        chk(acks, DEPTH);
        u_dcfgp_reader.gotD.delete();
        u_dcfgp_reader.gotS.delete();
        rdStall = 1'b0;
        $display("test_fill done");
    endtask
    // Clean, single, double-adjacent and triple-adjacent stored errors.
    task automatic test_ecc;
        for (i = 0; i < 4; i++) put(32'h5a5a0000 + i, flips[i]);
        idle(1);
        await(4);
        for (i = 0; i < 4; i++) chk(u_dcfgp_reader.gotS[i], stats[i]);
        for (i = 0; i < 3; i++) chk(u_dcfgp_reader.gotD[i], 32'h5a5a0000 + i);
        u_dcfgp_reader.gotD.delete();
        u_dcfgp_reader.gotS.delete();
        $display("test_ecc done");
    endtask
    // Reads while empty must leave the pointers alone.
    task automatic test_under;
        rdRude = 1'b1;
        repeat (40) @(negedge mclk);
        chk(u_dcfgp_reader.gotD.size(), 0);
        put(32'hc0de, 44'h0);
        idle(1);
        await(1);
        chk(u_dcfgp_reader.gotD[0], 32'hc0de);
        chk(acks, DEPTH + 5);
        rdRude = 1'b0;
        $display("test_under done");
    endtask

    initial begin
        reset_n = 1'b0;
        wrReq = 1'b0;
        wrData = 32'h0;
        wrFlip = 44'h0;
        rdEn = 1'b0;
        rdStall = 1'b0;
        rdRude = 1'b0;
        fails = 0;
        num_checks = 0;
        repeat (12) @(negedge mclk);
        reset_n = 1'b1;
        repeat (10) @(negedge mclk);
        test_reset;
        test_fill;
        test_ecc;
        test_under;
        give_verdict;
    end
    // Watchdog well beyond the few hundred cycles the tests need.
    initial begin
        #200000;
        fails++;
        give_verdict;
    end
endmodule
`default_nettype wire
